// ===== mcsp_cfg.svh
`ifndef MCSP_CFG_SVH
`define MCSP_CFG_SVH
// ---------------------------------------------
// register indexes, byte address is four times
// ---------------------------------------------
`define MCSP_IDX_CTRLA 8'h00
`define MCSP_IDX_CTRLB 8'h01
`define MCSP_IDX_LOCK 8'h02
`define MCSP_IDX_STATUS 8'h03
`define MCSP_IDX_FASTCTRL 8'h10
`define MCSP_IDX_CALIBA 8'h11
`define MCSP_IDX_CALIBB 8'h12
`define MCSP_IDX_SLOWCTRL 8'h18
`define MCSP_IDX_FERR 8'h19
`define MCSP_IDX_UNLOCK 8'h20
// ---------------------------------------------
// field positions and values
// ---------------------------------------------
`define MCSP_CLKOUT_BIT 7
`define MCSP_RSB_BIT 1
`define MCSP_SEL_FAST 2'h0
`define MCSP_SEL_SLOW 2'h1
`define MCSP_SEL_RSVD 2'h2
`define MCSP_SEL_EXT 2'h3
`define MCSP_CTRLB_RESET 8'h11
`define MCSP_UNLOCK_KEY 8'h5a
`define MCSP_UNLOCK_WINDOW 3'h4
// ---------------------------------------------
// timing
// ---------------------------------------------
`define MCSP_CLK_KHZ 20000
`define MCSP_FAST_START_NS 2000
`define MCSP_SLOW_START_NS 5000
`define MCSP_TAIL_EDGES 3'h4
`define MCSP_EXT_EDGES 3'h2
`define MCSP_KHZ_DIV 6'h20
`endif

// ===== mcsp_pkg.sv
package mcsp_pkg;
  typedef enum logic [1:0] {
    MCSP_ACTIVE = 2'b00,
    MCSP_IDLE = 2'b01,
    MCSP_STANDBY = 2'b10,
    MCSP_POWERDOWN = 2'b11
  } mcsp_sleep_type;

  typedef enum logic [1:0] {
    MCSP_OSC_OFF = 2'b00,
    MCSP_OSC_START = 2'b01,
    MCSP_OSC_TAIL = 2'b10,
    MCSP_OSC_READY = 2'b11
  } mcsp_osc_type;

  typedef struct packed {
    logic ext_clock_started;
    logic slow_ready;
    logic fast_ready;
    logic source_switch_pending;
  } mcsp_status_type;

  typedef struct packed {
    logic [3:0] prescale_divide;
    logic prescale_enable;
  } mcsp_ctrlb_type;
endpackage : mcsp_pkg

// ===== mcsp_top.sv
`timescale 1ns/10ps
`include "mcsp_cfg.svh"
module mcsp_top #(
  parameter int fast_start_cycles = (`MCSP_FAST_START_NS * `MCSP_CLK_KHZ + 999999) / 1000000,
  parameter int slow_start_cycles = (`MCSP_SLOW_START_NS * `MCSP_CLK_KHZ + 999999) / 1000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] sleep_mode,
  input wire logic nvm_busy,
  input wire logic [2:0] peripheral_request,
  input wire logic [2:0] source_clock,
  input wire logic frequency_select_fuse,
  input wire logic trim_lock_fuse,
  input wire logic [5:0] centre_trim_fuse,
  input wire logic [3:0] temp_slope_trim_fuse,
  input wire logic [7:0] frequency_error_fuse,
  output logic [2:0] source_enable,
  output logic main_clock_tick,
  output logic peripheral_clock_tick,
  output logic khz_tick,
  output logic clock_out_enable,
  output logic fast_rc_20mhz,
  output logic [5:0] centre_trim,
  output logic [3:0] temp_slope_trim
);
  // ---------------------------------------------
  // declarations
  // ---------------------------------------------
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  logic [1:0] main_source_select;
  logic [1:0] current_source;
  logic source_switch_pending;
  logic clock_out;
  mcsp_pkg::mcsp_ctrlb_type ctrlb;
  mcsp_pkg::mcsp_status_type status;
  logic main_clock_lock_enable;
  logic [1:0] run_in_standby;
  logic [2:0] unlock_count;
  logic [7:0] frequency_error;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic [2:0] source_edge;
  logic [2:0] source_ready;
  logic [2:0] need;
  logic main_run;
  logic [5:0] prescale_count;
  logic [6:0] active_divisor;
  logic [1:0] cur_bit;
  logic [1:0] sel_bit;
  logic [5:0] khz_count;
  logic do_write;
  logic unlocked;
  logic trim_frozen;
  logic [7:0] read_value;
  logic read_known;
  logic [7:0] ar_index;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // divide by 64 needs a seventh bit
  function automatic logic [6:0] divisor_of(input mcsp_pkg::mcsp_ctrlb_type cb);
    if (!cb.prescale_enable)
    begin
      return 7'h01;
    end
    case (cb.prescale_divide)
      4'h0: return 7'h02;
      4'h1: return 7'h04;
      4'h2: return 7'h08;
      4'h3: return 7'h10;
      4'h4: return 7'h20;
      4'h5: return 7'h40;
      4'h8: return 7'h06;
      4'h9: return 7'h0a;
      4'ha: return 7'h0c;
      4'hb: return 7'h18;
      4'hc: return 7'h30;
      default: return 7'h02;
    endcase
  endfunction : divisor_of

  // external code 3 sits on source bit 2
  function automatic logic [1:0] bit_of(input logic [1:0] sel);
    return (sel == `MCSP_SEL_EXT) ? 2'h2 : sel;
  endfunction : bit_of

  // ---------------------------------------------
  // pin synchronisers, edge on second and third
  // ---------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_src
      logic [2:0] tail_count;
      logic [9:0] wait_count;
      mcsp_pkg::mcsp_osc_type osc_state;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
          sync_c[g] <= 1'b0;
        end
        else
        begin
          sync_a[g] <= source_clock[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
        end
      end
      assign source_edge[g] = sync_b[g] & ~sync_c[g];
      // start-up timer (none for the external source), then a tail of source edges
      always_ff @(posedge aclk)
      begin
        if (!aresetn || !need[g])
        begin
          osc_state <= mcsp_pkg::MCSP_OSC_OFF;
          wait_count <= 10'h000;
          tail_count <= 3'h0;
        end
        else
        begin
          case (osc_state)
            mcsp_pkg::MCSP_OSC_OFF:
            begin
              wait_count <= 10'h000;
              tail_count <= 3'h0;
              osc_state <= (g == 2) ? mcsp_pkg::MCSP_OSC_TAIL : mcsp_pkg::MCSP_OSC_START;
            end
            mcsp_pkg::MCSP_OSC_START:
            begin
              wait_count <= wait_count + 10'h001;
              if (int'(wait_count) + 1 >= ((g == 0) ? fast_start_cycles : slow_start_cycles))
              begin
                osc_state <= mcsp_pkg::MCSP_OSC_TAIL;
              end
            end
            mcsp_pkg::MCSP_OSC_TAIL:
            begin
              if (source_edge[g])
              begin
                tail_count <= tail_count + 3'h1;
                if (tail_count + 3'h1 >= ((g == 2) ? `MCSP_EXT_EDGES : `MCSP_TAIL_EDGES))
                begin
                  osc_state <= mcsp_pkg::MCSP_OSC_READY;
                end
              end
            end
            mcsp_pkg::MCSP_OSC_READY:
            begin
              osc_state <= mcsp_pkg::MCSP_OSC_READY;
            end
            default:
            begin
              osc_state <= mcsp_pkg::MCSP_OSC_OFF;
            end
          endcase
        end
      end
      assign source_ready[g] = (osc_state == mcsp_pkg::MCSP_OSC_READY);
    end
  endgenerate

  // ---------------------------------------------
  // clock demand
  // ---------------------------------------------
  assign cur_bit = bit_of(current_source);
  assign sel_bit = bit_of(main_source_select);

  always_comb
  begin
    case (mcsp_pkg::mcsp_sleep_type'(sleep_mode))
      mcsp_pkg::MCSP_ACTIVE: main_run = 1'b1;
      mcsp_pkg::MCSP_IDLE: main_run = 1'b1;
      mcsp_pkg::MCSP_STANDBY: main_run = (|peripheral_request) |
        (current_source != `MCSP_SEL_EXT && run_in_standby[current_source[0]]);
      mcsp_pkg::MCSP_POWERDOWN: main_run = nvm_busy;
      default: main_run = 1'b1;
    endcase
  end

  generate
    for (g = 0; g < 3; g++)
    begin : gen_need
      assign need[g] = peripheral_request[g] |
        (main_run && int'(cur_bit) == g) |
        (source_switch_pending && int'(sel_bit) == g) |
        (g < 2 && run_in_standby[g % 2] && sleep_mode != mcsp_pkg::MCSP_POWERDOWN);
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      source_enable <= 3'h0;
    end
    else
    begin
      source_enable <= need;
    end
  end

  // ---------------------------------------------
  // main, peripheral and kilohertz ticks
  // ---------------------------------------------
  // ticks are whole source edges, so a switch cannot cut a pulse short
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_clock_tick <= 1'b0;
    end
    else
    begin
      main_clock_tick <= main_run && source_edge[cur_bit] && source_ready[cur_bit];
    end
  end

  // new ratio is taken only at wrap: no runt on the divided clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescale_count <= 6'h00;
      active_divisor <= 7'h06;
      peripheral_clock_tick <= 1'b0;
    end
    else
    begin
      peripheral_clock_tick <= 1'b0;
      if (main_clock_tick)
      begin
        if ({1'b0, prescale_count} + 7'h01 >= active_divisor)
        begin
          prescale_count <= 6'h00;
          peripheral_clock_tick <= 1'b1;
          active_divisor <= divisor_of(ctrlb);
        end
        else
        begin
          prescale_count <= prescale_count + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      khz_count <= 6'h00;
      khz_tick <= 1'b0;
    end
    else
    begin
      khz_tick <= 1'b0;
      if (source_edge[1] && source_ready[1])
      begin
        khz_count <= (khz_count + 6'h01 >= `MCSP_KHZ_DIV) ? 6'h00 : khz_count + 6'h01;
        khz_tick <= (khz_count + 6'h01 >= `MCSP_KHZ_DIV);
      end
    end
  end

  // ---------------------------------------------
  // source switching
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      current_source <= `MCSP_SEL_FAST;
      source_switch_pending <= 1'b0;
    end
    else if (source_switch_pending && source_ready[sel_bit])
    begin
      current_source <= main_source_select;
      source_switch_pending <= 1'b0;
    end
    else if (main_source_select != current_source)
    begin
      source_switch_pending <= 1'b1;
    end
  end

  // ---------------------------------------------
  // axi4-lite write side
  // ---------------------------------------------
  assign unlocked = (unlock_count != 3'h0);
  assign trim_frozen = trim_lock_fuse ||
    (main_clock_lock_enable && current_source == `MCSP_SEL_FAST);
  assign do_write = aw_held && w_held && !bvalid;
  assign w_byte = w_lane ? wdata[7:0] : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_index <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        awready <= 1'b0;
        aw_index <= awaddr[9:2];
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        wready <= 1'b0;
        w_lane <= wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= read_map(aw_index) ? resp_okay : resp_slverr;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  function automatic logic read_map(input logic [7:0] idx);
    case (idx)
      `MCSP_IDX_CTRLA, `MCSP_IDX_CTRLB, `MCSP_IDX_LOCK, `MCSP_IDX_STATUS,
      `MCSP_IDX_FASTCTRL, `MCSP_IDX_CALIBA, `MCSP_IDX_CALIBB,
      `MCSP_IDX_SLOWCTRL, `MCSP_IDX_FERR, `MCSP_IDX_UNLOCK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : read_map

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unlock_count <= 3'h0;
    end
    else if (do_write && aw_index == `MCSP_IDX_UNLOCK && w_byte == `MCSP_UNLOCK_KEY)
    begin
      unlock_count <= `MCSP_UNLOCK_WINDOW;
    end
    else if (do_write || unlocked)
    begin
      unlock_count <= (do_write || unlock_count == 3'h0) ? 3'h0 : unlock_count - 3'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_source_select <= `MCSP_SEL_FAST;
      clock_out <= 1'b0;
      ctrlb <= mcsp_pkg::mcsp_ctrlb_type'(5'(`MCSP_CTRLB_RESET));
      main_clock_lock_enable <= trim_lock_fuse;
      run_in_standby <= 2'h0;
      centre_trim <= centre_trim_fuse;
      temp_slope_trim <= temp_slope_trim_fuse;
      fast_rc_20mhz <= frequency_select_fuse;
      frequency_error <= frequency_error_fuse;
    end
    else if (do_write && w_lane && unlocked)
    begin
      case (aw_index)
        `MCSP_IDX_CTRLA:
        begin
          if (!main_clock_lock_enable)
          begin
            clock_out <= w_byte[`MCSP_CLKOUT_BIT];
            if (!source_switch_pending && w_byte[1:0] != `MCSP_SEL_RSVD)
            begin
              main_source_select <= w_byte[1:0];
            end
          end
        end
        `MCSP_IDX_CTRLB:
        begin
          if (!main_clock_lock_enable)
          begin
            ctrlb <= mcsp_pkg::mcsp_ctrlb_type'(w_byte[4:0]);
          end
        end
        `MCSP_IDX_LOCK:
        begin
          if (!main_clock_lock_enable)
          begin
            main_clock_lock_enable <= w_byte[0];
          end
        end
        `MCSP_IDX_FASTCTRL: run_in_standby[0] <= w_byte[`MCSP_RSB_BIT];
        `MCSP_IDX_SLOWCTRL: run_in_standby[1] <= w_byte[`MCSP_RSB_BIT];
        `MCSP_IDX_CALIBA:
        begin
          if (!trim_frozen)
          begin
            centre_trim <= w_byte[5:0];
          end
        end
        `MCSP_IDX_CALIBB:
        begin
          if (!trim_frozen)
          begin
            temp_slope_trim <= w_byte[3:0];
          end
        end
        default:
        begin
          clock_out <= clock_out;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_out_enable <= 1'b0;
    end
    else
    begin
      clock_out_enable <= clock_out && main_run;
    end
  end

  // ---------------------------------------------
  // axi4-lite read side
  // ---------------------------------------------
  assign status = '{ext_clock_started: source_ready[2], slow_ready: source_ready[1],
    fast_ready: source_ready[0], source_switch_pending: source_switch_pending};
  assign ar_index = araddr[9:2];

  always_comb
  begin
    read_known = read_map(ar_index);
    case (ar_index)
      `MCSP_IDX_CTRLA: read_value = {clock_out, 5'h00, main_source_select};
      `MCSP_IDX_CTRLB: read_value = {3'h0, ctrlb};
      `MCSP_IDX_LOCK: read_value = {7'h00, main_clock_lock_enable};
      `MCSP_IDX_STATUS: read_value = {status[3], 1'b0, status[2:1], 3'h0, status[0]};
      `MCSP_IDX_FASTCTRL: read_value = {6'h00, run_in_standby[0], 1'b0};
      `MCSP_IDX_SLOWCTRL: read_value = {6'h00, run_in_standby[1], 1'b0};
      `MCSP_IDX_CALIBA: read_value = {2'h0, centre_trim};
      `MCSP_IDX_CALIBB: read_value = {trim_lock_fuse, 3'h0, temp_slope_trim};
      `MCSP_IDX_FERR: read_value = frequency_error;
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= resp_okay;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, read_value};
      rresp <= read_known ? resp_okay : resp_slverr;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : mcsp_top

// ===== mcsp_monitor.sv
`timescale 1ns/10ps
// ------------------
// port checker
// ------------------
module mcsp_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] sleep_mode,
  input wire logic nvm_busy,
  input wire logic frequency_select_fuse,
  input wire logic [5:0] centre_trim_fuse,
  input wire logic [3:0] temp_slope_trim_fuse,
  input wire logic main_clock_tick,
  input wire logic peripheral_clock_tick,
  input wire logic khz_tick,
  input wire logic clock_out_enable,
  input wire logic fast_rc_20mhz,
  input wire logic [5:0] centre_trim,
  input wire logic [3:0] temp_slope_trim
);
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ready_low: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready during response");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  a_reset_defaults: assert property (disable iff (1'b0) $past(!aresetn) |->
    !clock_out_enable && !bvalid && !rvalid) else $error("reset state wrong");
  a_fuse_copy: assert property (disable iff (1'b0) $past(!aresetn) |->
    fast_rc_20mhz == $past(frequency_select_fuse) && centre_trim == $past(centre_trim_fuse)
    && temp_slope_trim == $past(temp_slope_trim_fuse)) else $error("fuse copy wrong");
  a_main_no_runt: assert property (main_clock_tick |=> !main_clock_tick)
    else $error("main clock runt");
  a_per_no_runt: assert property (peripheral_clock_tick |=> !peripheral_clock_tick)
    else $error("peripheral clock runt");
  a_khz_spacing: assert property (khz_tick |=> (!khz_tick) [*8])
    else $error("kilohertz tick too close");
  a_powerdown_stop: assert property
    ((sleep_mode == mcsp_pkg::MCSP_POWERDOWN && !nvm_busy) [*8] |-> !main_clock_tick)
    else $error("main clock runs in power-down");
endmodule : mcsp_monitor

// ===== mcsp_osc_model.sv
`timescale 1ns/10ps
// ----------------------------
// oscillators and clock pin
// ----------------------------
module mcsp_osc_model (
  input wire logic aclk,
  input wire logic [2:0] source_enable,
  input wire logic ext_run,
  output logic [2:0] source_clock
);
  int cnt [3] = '{0, 0, 0};
  initial source_clock = 3'h0;
  // disabled internal sources stand still, so no edge can fake a start-up; the external pin follows ext_run, not source_enable
  always @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if ((i == 2) ? ext_run : source_enable[i])
      begin
        cnt[i] <= (cnt[i] == i + 1) ? 0 : cnt[i] + 1;
        if (cnt[i] == i + 1)
          source_clock[i] <= !source_clock[i];
      end
    end
  end
endmodule : mcsp_osc_model

// ===== mcsp_top_bench.sv
`timescale 1ns/10ps
`include "mcsp_cfg.svh"
module mcsp_top_bench;
  localparam int FAST = 8;
  localparam int SLOW = 8;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, nvm_busy = 1'b0, ext_run = 1'b0;
  logic frequency_select_fuse = 1'b1, trim_lock_fuse = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, temp_slope_trim_fuse = 4'h9, temp_slope_trim;
  logic [1:0] sleep_mode = 2'h0, bresp, rresp, last_rresp;
  logic [2:0] peripheral_request = 3'h0, source_clock, source_enable;
  logic [5:0] centre_trim_fuse = 6'h15, centre_trim;
  logic [7:0] frequency_error_fuse = 8'ha5;
  logic awready, wready, bvalid, arready, rvalid, main_clock_tick, peripheral_clock_tick;
  logic khz_tick, clock_out_enable, fast_rc_20mhz;
  int fail_count = 0, n_tests = 0, cyc = 0;
  mcsp_top #(.fast_start_cycles(FAST), .slow_start_cycles(SLOW)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .bresp, .bvalid,
    .bready, .wready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sleep_mode, .nvm_busy, .peripheral_request, .source_clock, .frequency_select_fuse,
    .trim_lock_fuse, .centre_trim_fuse, .temp_slope_trim_fuse, .frequency_error_fuse,
    .source_enable, .main_clock_tick, .peripheral_clock_tick, .khz_tick, .clock_out_enable,
    .fast_rc_20mhz, .centre_trim, .temp_slope_trim);
  mcsp_osc_model osc (.aclk, .source_enable, .ext_run, .source_clock);
  always #25 aclk = ~aclk;
  // ------------------
  // shared tasks
  // ------------------
  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      aw_done = aw_done || awready === 1'b1;
      w_done = w_done || wready === 1'b1;
      awvalid <= !aw_done;
      wvalid <= !w_done;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic pwr(input logic [7:0] idx, input logic [7:0] d);
    wr(`MCSP_IDX_UNLOCK, `MCSP_UNLOCK_KEY);
    wr(idx, d);
  endtask : pwr
  function automatic logic pick(input int s);
    return (s == 0) ? main_clock_tick : (s == 1) ? peripheral_clock_tick : khz_tick;
  endfunction : pick
  // cycles between two pulses, steady state only
  task automatic gap(input int s, output int n);
    n = 0;
    do @(posedge aclk); while (pick(s) !== 1'b1);
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (pick(s) !== 1'b1 && n < 3000);
  endtask : gap
  task automatic sl(input logic [1:0] m, input logic [2:0] q, input logic b, input logic e);
    int n;
    @(posedge aclk);
    sleep_mode <= m;
    peripheral_request <= q;
    nvm_busy <= b;
    repeat (12) @(posedge aclk);
    n = 0;
    repeat (48) @(posedge aclk) n += (main_clock_tick === 1'b1);
    chk(n != 0, e);
  endtask : sl
  task automatic rst(input logic f);
    int n;
    @(posedge aclk);
    aresetn <= 1'b0;
    trim_lock_fuse <= f;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    do @(posedge aclk) n++; while (main_clock_tick !== 1'b1 && n < 2000);
    chk(n >= FAST + 12, 1'b1);
  endtask : rst
  // ------------------
  // scenarios
  // ------------------
  task automatic t_reset();
    logic [31:0] d;
    int n;
    rd(`MCSP_IDX_CTRLA, d);
    chk(d, 32'h0);
    rd(`MCSP_IDX_CTRLB, d);
    chk(d[7:0], `MCSP_CTRLB_RESET);
    rd(`MCSP_IDX_FERR, d);
    chk(d[7:0], 8'ha5);
    rd(`MCSP_IDX_CALIBA, d);
    chk(d[5:0], 6'h15);
    rd(`MCSP_IDX_STATUS, d);
    chk(d[4], 1'b1);
    rd(8'h05, d);
    chk(last_rresp, 2'h2);
    gap(0, n);
    chk(n, 4);
    gap(1, n);
    chk(n, 24);
  endtask : t_reset
  task automatic t_protect();
    logic [31:0] d;
    wr(`MCSP_IDX_CTRLB, 8'h01);
    rd(`MCSP_IDX_CTRLB, d);
    chk(d[7:0], 8'h11);
    wr(`MCSP_IDX_UNLOCK, `MCSP_UNLOCK_KEY);
    repeat (8) @(posedge aclk);
    wr(`MCSP_IDX_CTRLB, 8'h01);
    rd(`MCSP_IDX_CTRLB, d);
    chk(d[7:0], 8'h11);
  endtask : t_protect
  task automatic t_divs();
    logic [3:0] code [12] = '{0, 1, 2, 3, 4, 5, 8, 9, 4'ha, 4'hb, 4'hc, 6};
    int div [12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 2};
    int n;
    for (int i = 0; i < 12; i++)
    begin
      pwr(`MCSP_IDX_CTRLB, {3'h0, code[i], 1'b1});
      gap(1, n);
      gap(1, n);
      chk(n, div[i] * 4);
    end
    pwr(`MCSP_IDX_CTRLB, 8'h10);
    gap(1, n);
    gap(1, n);
    chk(n, 4);
    pwr(`MCSP_IDX_CTRLB, 8'h11);
  endtask : t_divs
  task automatic t_calib();
    wr(`MCSP_IDX_CALIBA, 8'h2a);
    chk(centre_trim, 6'h15);
    pwr(`MCSP_IDX_CTRLB, 8'h0b);
    pwr(`MCSP_IDX_CALIBA, 8'h2a);
    pwr(`MCSP_IDX_CALIBB, 8'h05);
    pwr(`MCSP_IDX_CTRLB, 8'h11);
    chk(centre_trim, 6'h2a);
    chk(temp_slope_trim, 4'h5);
  endtask : t_calib
  task automatic t_slow();
    logic [31:0] d;
    int n;
    pwr(`MCSP_IDX_CTRLA, 8'h81);
    rd(`MCSP_IDX_STATUS, d);
    chk(d[0], 1'b1);
    repeat (80) @(posedge aclk);
    rd(`MCSP_IDX_STATUS, d);
    chk({d[5], d[0]}, 2'b10);
    gap(0, n);
    chk(n, 6);
    chk(source_enable, 3'h2);
    chk(clock_out_enable, 1'b1);
    pwr(`MCSP_IDX_CTRLA, 8'h02);
    rd(`MCSP_IDX_CTRLA, d);
    chk(d[1:0], 2'h1);
    @(posedge aclk) peripheral_request <= 3'h1;
    repeat (4) @(posedge aclk);
    chk(source_enable[0], 1'b1);
    gap(2, n);
    chk(n, 192);
    sl(mcsp_pkg::MCSP_STANDBY, 3'h0, 1'b0, 1'b0);
    sl(mcsp_pkg::MCSP_STANDBY, 3'h2, 1'b0, 1'b1);
    sl(mcsp_pkg::MCSP_IDLE, 3'h0, 1'b0, 1'b1);
    pwr(`MCSP_IDX_SLOWCTRL, 8'h02);
    sl(mcsp_pkg::MCSP_STANDBY, 3'h0, 1'b0, 1'b1);
    sl(mcsp_pkg::MCSP_POWERDOWN, 3'h0, 1'b1, 1'b1);
    sl(mcsp_pkg::MCSP_POWERDOWN, 3'h0, 1'b0, 1'b0);
    sl(mcsp_pkg::MCSP_ACTIVE, 3'h0, 1'b0, 1'b1);
  endtask : t_slow
  task automatic t_ext();
    logic [31:0] d;
    int n;
    pwr(`MCSP_IDX_CTRLA, 8'h03);
    repeat (20) @(posedge aclk);
    rd(`MCSP_IDX_STATUS, d);
    chk({d[7], d[0]}, 2'b01);
    pwr(`MCSP_IDX_CTRLA, 8'h00);
    gap(0, n);
    chk(n, 6);
    @(posedge aclk) ext_run <= 1'b1;
    repeat (40) @(posedge aclk);
    rd(`MCSP_IDX_STATUS, d);
    chk({d[7], d[0]}, 2'b10);
    gap(0, n);
    chk(n, 8);
  endtask : t_ext
  task automatic t_lock();
    int n;
    rst(1'b0);
    gap(0, n);
    chk(n, 4);
    pwr(`MCSP_IDX_LOCK, 8'h01);
    pwr(`MCSP_IDX_CALIBA, 8'h33);
    chk(centre_trim, 6'h15);
    rst(1'b1);
    pwr(`MCSP_IDX_CALIBA, 8'h33);
    chk(centre_trim, 6'h15);
  endtask : t_lock
  initial
  begin
    rst(1'b0);
    t_reset();
    t_protect();
    t_divs();
    t_calib();
    t_slow();
    t_ext();
    t_lock();
    complete_run();
  end
endmodule : mcsp_top_bench
bind mcsp_top mcsp_monitor mon (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .sleep_mode,
  .nvm_busy, .frequency_select_fuse, .centre_trim_fuse, .temp_slope_trim_fuse,
  .main_clock_tick, .peripheral_clock_tick, .khz_tick, .clock_out_enable, .fast_rc_20mhz,
  .centre_trim, .temp_slope_trim);
